/* core/lstc_pkg.sv */
package lstc_pkg;
	// operation select
	typedef enum logic [1:0] {
		LSTC_OP_B2BCD = 2'h0,
		LSTC_OP_BCD2B = 2'h1,
		LSTC_OP_HMS = 2'h2
	} lstc_op_t;

	// unit sequencing states, one-hot
	typedef enum logic [3:0] {
		LSTC_ST_IDLE = 4'h1,
		LSTC_ST_DIV = 4'h2,
		LSTC_ST_CONV = 4'h4,
		LSTC_ST_DONE = 4'h8
	} lstc_state_t;

	// arithmetic limits and counts
	localparam logic [31:0] LSTC_BCD_MAX_MAG = 32'h0000_270F;
	localparam logic [7:0] LSTC_TIME_FIELD_MAX = 8'h3B;
	localparam logic [11:0] LSTC_SEC_PER_HOUR = 12'hE10;
	localparam logic [5:0] LSTC_SEC_PER_MIN = 6'h3C;
	localparam logic [5:0] LSTC_DIV_STEPS = 6'h20;
	localparam logic [5:0] LSTC_DABBLE_STEPS = 6'h1B;
	localparam logic [15:0] LSTC_RSV_LO = 16'h1800;
	localparam logic [15:0] LSTC_RSV_HI = 16'h19FF;

	// controller register byte offsets
	localparam logic [5:0] LSTC_REG_CTRL = 6'h00;
	localparam logic [5:0] LSTC_REG_SRC0 = 6'h04;
	localparam logic [5:0] LSTC_REG_SRC1 = 6'h08;
	localparam logic [5:0] LSTC_REG_PRM0 = 6'h0C;
	localparam logic [5:0] LSTC_REG_DEST = 6'h20;
	localparam logic [5:0] LSTC_REG_AREA = 6'h24;
	localparam logic [5:0] LSTC_REG_RES0 = 6'h28;
	localparam logic [5:0] LSTC_REG_RES1 = 6'h2C;
	localparam logic [5:0] LSTC_REG_STAT = 6'h30;
	localparam logic [5:0] LSTC_REG_IRQ_STAT = 6'h34;
	localparam logic [5:0] LSTC_REG_IRQ_MASK = 6'h38;
	localparam int LSTC_PRM_WORDS = 5;

	// control bits
	localparam int LSTC_CTRL_EXEC = 2;
	localparam int LSTC_CTRL_GO = 3;
	localparam int LSTC_CTRL_SET_CARRY = 4;
	localparam int LSTC_CTRL_CLR_CARRY = 5;
	// area-ok bits
	localparam int LSTC_AREA_SRC = 0;
	localparam int LSTC_AREA_PRM = 1;
	localparam int LSTC_AREA_RES = 2;
	// status bits
	localparam int LSTC_STAT_BUSY = 0;
	localparam int LSTC_STAT_ERR = 1;
	localparam int LSTC_STAT_CARRY = 2;
	localparam int LSTC_STAT_EQ = 3;
	// interrupt bits
	localparam int LSTC_IRQ_DONE = 0;
	localparam int LSTC_IRQ_ERR = 1;
	localparam int LSTC_IRQ_REFUSED = 2;
	localparam int LSTC_IRQ_W = 3;

	// reset values
	localparam logic [15:0] LSTC_WORD_RST = 16'h0000;
	localparam logic [2:0] LSTC_AREA_RST = 3'h7;
endpackage

/* core/lstc_if.sv */
`timescale 1ns/100ps
interface lstc_if;
	import lstc_pkg::*;
	logic start;
	logic [1:0] op_sel;
	logic exec_cond;
	logic carry_in;
	logic [15:0] src0;
	logic [15:0] src1;
	logic [4:0][15:0] prm;
	logic src_area_ok;
	logic prm_area_ok;
	logic res_area_ok;
	logic done;
	logic busy;
	logic [15:0] res0;
	logic [15:0] res1;
	logic error_flag;
	logic carry_sign_flag;
	logic equal_zero_flag;

	modport dev (
		input start, op_sel, exec_cond, carry_in, src0, src1, prm,
		input src_area_ok, prm_area_ok, res_area_ok,
		output done, busy, res0, res1, error_flag, carry_sign_flag,
		output equal_zero_flag
	);
	modport seq (
		output start, op_sel, exec_cond, carry_in, src0, src1, prm,
		output src_area_ok, prm_area_ok, res_area_ok,
		input done, busy, res0, res1, error_flag, carry_sign_flag,
		input equal_zero_flag
	);
endinterface

/* core/lstc_unit.sv */
// Notes on behaviour
// - condition false: no conversion, results and flags kept
// - binary scale: dY/dX times (S minus intercept), rounded
// - negative sets carry; magnitude clamps at 9999
// - intercept, signed dX, BCD dY words
// - parameter area or setting fault raises error flag
// - BCD scale: dY/dX times S plus intercept
// - carry gives BCD source its sign
// - clamp to upper word four, lower word five
// - five words; BCD dX 1..9999, signed dY
// - non-BCD source raises error flag
// - BCD scale leaves carry unchanged
// - scaling sets equal flag on zero result
// - results never aimed at reserved range
// - seconds low byte, minutes high, hours next
// - seconds total as eight BCD digits
// - field over 59, non-BCD, area fault: error
// - zero seconds total sets equal flag
//
// Decided for this implementation: register access over Avalon-MM and the register addresses.
`timescale 1ns/100ps
module lstc_unit
	import lstc_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	input wire logic ce,
	// sequencer side
	lstc_if.dev link
);
	function automatic logic bcd_ok(input logic [15:0] w);
		logic ok;
		ok = 1'b1;
		for (int i = 0; i < 4; i++) begin
			if (w[4*i +: 4] > 4'h9) begin
				ok = 1'b0;
			end
		end
		return ok;
	endfunction

	function automatic logic [13:0] bcd_val(input logic [15:0] w);
		return 14'(w[15:12]) * 14'h03E8 + 14'(w[11:8]) * 14'h0064 +
			14'(w[7:4]) * 14'h000A + 14'(w[3:0]);
	endfunction

	lstc_state_t state;
	logic [1:0] op_q;
	logic neg_q;
	logic carry_q;
	logic [15:0] icpt_q;
	logic [15:0] upper_q;
	logic [15:0] lower_q;
	logic [31:0] quo;
	logic [18:0] rem;
	logic [17:0] div_q;
	logic [5:0] step;
	logic [26:0] dab_bin;
	logic [31:0] dab_bcd;

	// operand decode
	logic signed [16:0] s_minus_p;
	logic signed [31:0] b2b_num;
	logic signed [31:0] d2b_num;
	logic [13:0] d2b_src;
	logic [13:0] d2b_dx;
	logic [16:0] b2b_den;
	logic [31:0] mag;
	logic [16:0] den;
	logic neg;
	logic [7:0] sec_b;
	logic [7:0] min_b;
	logic [26:0] hms_total;
	logic op_err;
	logic accept;

	always_comb begin
		s_minus_p = $signed({link.src0[15], link.src0}) -
			$signed({link.prm[0][15], link.prm[0]});
		b2b_num = 32'(s_minus_p * $signed({3'h0, bcd_val(link.prm[2])}));
		d2b_src = bcd_val(link.src0);
		d2b_dx = bcd_val(link.prm[1]);
		d2b_num = 32'($signed(link.prm[2]) * $signed({2'h0, d2b_src}));
		b2b_den = link.prm[1][15] ? 17'(-$signed({1'b1, link.prm[1]})) :
			{1'b0, link.prm[1]};
		sec_b = 8'(link.src0[7:4]) * 8'h0A + 8'(link.src0[3:0]);
		min_b = 8'(link.src0[15:12]) * 8'h0A + 8'(link.src0[11:8]);
		hms_total = 27'(bcd_val(link.src1)) * 27'(LSTC_SEC_PER_HOUR) +
			27'(min_b) * 27'(LSTC_SEC_PER_MIN) + 27'(sec_b);
		if (link.op_sel == LSTC_OP_B2BCD) begin
			mag = b2b_num[31] ? 32'(-b2b_num) : b2b_num;
			den = b2b_den;
			neg = b2b_num[31] ^ link.prm[1][15];
			op_err = !link.prm_area_ok || !bcd_ok(link.prm[2]) ||
				link.prm[1] == LSTC_WORD_RST;
		end else begin
			mag = d2b_num[31] ? 32'(-d2b_num) : d2b_num;
			den = {3'h0, d2b_dx};
			neg = d2b_num[31] ^ link.carry_in;
			op_err = !link.prm_area_ok || !bcd_ok(link.prm[1]) ||
				d2b_dx == 14'h0000;
			if (link.op_sel == LSTC_OP_BCD2B) begin
				op_err = op_err || !bcd_ok(link.src0);
			end else if (link.op_sel == LSTC_OP_HMS) begin
				op_err = !bcd_ok(link.src0) || !bcd_ok(link.src1) ||
					sec_b > LSTC_TIME_FIELD_MAX ||
					min_b > LSTC_TIME_FIELD_MAX ||
					!link.src_area_ok || !link.res_area_ok;
			end else begin
				op_err = 1'b1;
			end
		end
	end

	assign accept = ce && state == LSTC_ST_IDLE && link.start;

	// divider step and digit adjust
	logic [18:0] trial;
	logic [31:0] dab_adj;
	assign trial = {rem[17:0], quo[31]} - {1'b0, div_q};
	genvar g;
	generate
		for (g = 0; g < 8; g++) begin : g_digit
			assign dab_adj[4*g +: 4] = dab_bcd[4*g +: 4] > 4'h4 ?
				dab_bcd[4*g +: 4] + 4'h3 : dab_bcd[4*g +: 4];
		end
	endgenerate

	// finishing values
	logic signed [33:0] d2b_sum;
	logic [15:0] d2b_res;
	logic div_end;
	logic conv_end;
	always_comb begin
		d2b_sum = (neg_q ? -$signed({2'h0, quo}) : $signed({2'h0, quo})) +
			34'($signed(icpt_q));
		if (d2b_sum > 34'($signed(upper_q))) begin
			d2b_res = upper_q;
		end else if (d2b_sum < 34'($signed(lower_q))) begin
			d2b_res = lower_q;
		end else begin
			d2b_res = d2b_sum[15:0];
		end
	end
	assign div_end = state == LSTC_ST_DIV && step == LSTC_DIV_STEPS;
	assign conv_end = state == LSTC_ST_CONV && step == LSTC_DABBLE_STEPS;

	// sequencing
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state <= LSTC_ST_IDLE;
			step <= 6'h00;
		end else if (ce) begin
			case (state)
				LSTC_ST_IDLE: begin
					step <= 6'h00;
					if (link.start) begin
						if (!link.exec_cond || op_err) begin
							state <= LSTC_ST_DONE;
						end else if (link.op_sel == LSTC_OP_HMS) begin
							state <= LSTC_ST_CONV;
						end else begin
							state <= LSTC_ST_DIV;
						end
					end
				end
				LSTC_ST_DIV: begin
					if (!div_end) begin
						step <= step + 6'h01;
					end else begin
						step <= 6'h00;
						state <= op_q == LSTC_OP_B2BCD ? LSTC_ST_CONV :
							LSTC_ST_DONE;
					end
				end
				LSTC_ST_CONV: begin
					if (!conv_end) begin
						step <= step + 6'h01;
					end else begin
						state <= LSTC_ST_DONE;
					end
				end
				LSTC_ST_DONE: state <= LSTC_ST_IDLE;
				default: state <= LSTC_ST_IDLE;
			endcase
		end
	end

	// operand capture and arithmetic
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			op_q <= 2'h0;
			neg_q <= 1'b0;
			carry_q <= 1'b0;
			icpt_q <= LSTC_WORD_RST;
			upper_q <= LSTC_WORD_RST;
			lower_q <= LSTC_WORD_RST;
			quo <= 32'h0000_0000;
			rem <= 19'h0_0000;
			div_q <= 18'h0_0000;
			dab_bin <= 27'h000_0000;
			dab_bcd <= 32'h0000_0000;
		end else if (ce) begin
			if (accept) begin
				op_q <= link.op_sel;
				neg_q <= neg;
				carry_q <= link.carry_in;
				icpt_q <= link.prm[0];
				upper_q <= link.prm[3];
				lower_q <= link.prm[4];
				// rounding: (2*mag + den) / (2*den)
				quo <= (mag << 1) + 32'(den);
				rem <= 19'h0_0000;
				div_q <= {den, 1'b0};
				dab_bin <= hms_total;
				dab_bcd <= 32'h0000_0000;
			end else if (state == LSTC_ST_DIV && !div_end) begin
				rem <= trial[18] ? {rem[17:0], quo[31]} : trial;
				quo <= {quo[30:0], ~trial[18]};
			end else if (div_end) begin
				dab_bin <= quo > LSTC_BCD_MAX_MAG ? 27'(LSTC_BCD_MAX_MAG) :
					27'(quo);
			end else if (state == LSTC_ST_CONV && !conv_end) begin
				dab_bcd <= {dab_adj[30:0], dab_bin[26]};
				dab_bin <= {dab_bin[25:0], 1'b0};
			end
		end
	end

	// results and flags
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			link.res0 <= LSTC_WORD_RST;
			link.res1 <= LSTC_WORD_RST;
			link.error_flag <= 1'b0;
			link.carry_sign_flag <= 1'b0;
			link.equal_zero_flag <= 1'b0;
		end else if (ce) begin
			if (accept && link.exec_cond && op_err) begin
				link.error_flag <= 1'b1;
			end else if (div_end && op_q == LSTC_OP_BCD2B) begin
				link.res0 <= d2b_res;
				link.error_flag <= 1'b0;
				link.carry_sign_flag <= carry_q;
				link.equal_zero_flag <= d2b_res == LSTC_WORD_RST;
			end else if (conv_end && op_q == LSTC_OP_B2BCD) begin
				link.res0 <= dab_bcd[15:0];
				link.error_flag <= 1'b0;
				link.carry_sign_flag <= neg_q && dab_bcd[15:0] != 16'h0000;
				link.equal_zero_flag <= dab_bcd[15:0] == 16'h0000;
			end else if (conv_end) begin
				link.res0 <= dab_bcd[15:0];
				link.res1 <= dab_bcd[31:16];
				link.error_flag <= 1'b0;
				link.equal_zero_flag <= dab_bcd == 32'h0000_0000;
			end
		end
	end

	assign link.done = state == LSTC_ST_DONE;
	assign link.busy = state != LSTC_ST_IDLE;
endmodule

/* core/lstc_seq.sv */
`timescale 1ns/100ps
module lstc_seq
	import lstc_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	input wire logic ce,
	// avalon-mm slave
	input wire logic [5:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	output logic [31:0] readdata,
	output logic waitrequest,
	// interrupt
	output logic irq,
	// unit side
	lstc_if.seq link
);
	logic ack;
	logic wr_go;
	logic rd_go;
	logic [15:0] dest;
	logic [2:0] area;
	logic pending;
	logic [LSTC_IRQ_W-1:0] irq_stat;
	logic [LSTC_IRQ_W-1:0] irq_mask;
	logic [LSTC_IRQ_W-1:0] irq_evt;
	logic dest_bad;
	logic go_req;
	logic refuse;

	assign waitrequest = (read || write) && !(ack && ce);
	assign wr_go = ce && write && ack;
	assign rd_go = ce && read && ack;
	assign dest_bad = dest >= LSTC_RSV_LO && dest <= LSTC_RSV_HI;
	assign go_req = wr_go && address == LSTC_REG_CTRL &&
		writedata[LSTC_CTRL_GO];
	assign refuse = go_req && (pending || dest_bad);

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			ack <= 1'b0;
		end else if (ce) begin
			ack <= (read || write) && !ack;
		end
	end

	// order registers
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			link.op_sel <= 2'h0;
			link.exec_cond <= 1'b0;
			link.src0 <= LSTC_WORD_RST;
			link.src1 <= LSTC_WORD_RST;
			link.prm <= '0;
			dest <= LSTC_WORD_RST;
			area <= LSTC_AREA_RST;
		end else if (wr_go) begin
			if (address == LSTC_REG_CTRL) begin
				link.op_sel <= writedata[1:0];
				link.exec_cond <= writedata[LSTC_CTRL_EXEC];
			end
			if (address == LSTC_REG_SRC0) begin
				link.src0 <= writedata[15:0];
			end
			if (address == LSTC_REG_SRC1) begin
				link.src1 <= writedata[15:0];
			end
			for (int i = 0; i < LSTC_PRM_WORDS; i++) begin
				if (address == LSTC_REG_PRM0 + 6'(4 * i)) begin
					link.prm[i] <= writedata[15:0];
				end
			end
			if (address == LSTC_REG_DEST) begin
				dest <= writedata[15:0];
			end
			if (address == LSTC_REG_AREA) begin
				area <= writedata[2:0];
			end
		end
	end
	assign link.src_area_ok = area[LSTC_AREA_SRC];
	assign link.prm_area_ok = area[LSTC_AREA_PRM];
	assign link.res_area_ok = area[LSTC_AREA_RES];

	// start and carry
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			link.start <= 1'b0;
			pending <= 1'b0;
			link.carry_in <= 1'b0;
		end else if (ce) begin
			link.start <= go_req && !refuse;
			if (go_req && !refuse) begin
				pending <= 1'b1;
			end else if (link.done) begin
				pending <= 1'b0;
			end
			if (link.done) begin
				link.carry_in <= link.carry_sign_flag;
			end else if (wr_go && address == LSTC_REG_CTRL) begin
				if (writedata[LSTC_CTRL_SET_CARRY]) begin
					link.carry_in <= 1'b1;
				end else if (writedata[LSTC_CTRL_CLR_CARRY]) begin
					link.carry_in <= 1'b0;
				end
			end
		end
	end

	// interrupt status, cleared by read, set wins
	always_comb begin
		irq_evt = '0;
		irq_evt[LSTC_IRQ_DONE] = link.done;
		irq_evt[LSTC_IRQ_ERR] = link.done && link.error_flag;
		irq_evt[LSTC_IRQ_REFUSED] = refuse;
	end
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			irq_stat <= '0;
			irq_mask <= '0;
		end else if (ce) begin
			if (rd_go && address == LSTC_REG_IRQ_STAT) begin
				irq_stat <= (irq_stat & ~readdata[LSTC_IRQ_W-1:0]) | irq_evt;
			end else begin
				irq_stat <= irq_stat | irq_evt;
			end
			if (wr_go && address == LSTC_REG_IRQ_MASK) begin
				irq_mask <= writedata[LSTC_IRQ_W-1:0];
			end
		end
	end
	assign irq = |(irq_stat & irq_mask);

	// read data, ready at the edge where waitrequest is low
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			readdata <= 32'h0000_0000;
		end else if (ce && read && !ack) begin
			readdata <= 32'h0000_0000;
			case (address)
				LSTC_REG_CTRL: readdata <= {29'h0, link.exec_cond,
					link.op_sel};
				LSTC_REG_SRC0: readdata <= {16'h0000, link.src0};
				LSTC_REG_SRC1: readdata <= {16'h0000, link.src1};
				LSTC_REG_DEST: readdata <= {16'h0000, dest};
				LSTC_REG_AREA: readdata <= {29'h0, area};
				LSTC_REG_RES0: readdata <= {16'h0000, link.res0};
				LSTC_REG_RES1: readdata <= {16'h0000, link.res1};
				LSTC_REG_STAT: readdata <= {27'h0, 1'b0,
					link.equal_zero_flag, link.carry_in,
					link.error_flag, pending};
				LSTC_REG_IRQ_STAT: readdata <= {29'h0, irq_stat};
				LSTC_REG_IRQ_MASK: readdata <= {29'h0, irq_mask};
				default: begin
					for (int i = 0; i < LSTC_PRM_WORDS; i++) begin
						if (address == LSTC_REG_PRM0 + 6'(4 * i)) begin
							readdata <= {16'h0000, link.prm[i]};
						end
					end
				end
			endcase
		end
	end
endmodule

/* bench/lstc_assertions.sv */
`timescale 1ns/100ps
module lstc_assertions
	import lstc_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// sequencer to unit
	input wire logic start,
	input wire logic [1:0] op_sel,
	input wire logic exec_cond,
	input wire logic carry_in,
	input wire logic [15:0] src0,
	input wire logic [15:0] src1,
	input wire logic src_area_ok,
	input wire logic prm_area_ok,
	input wire logic res_area_ok,
	// unit to sequencer
	input wire logic done,
	input wire logic busy,
	input wire logic [15:0] res0,
	input wire logic [15:0] res1,
	input wire logic error_flag,
	input wire logic carry_sign_flag,
	input wire logic equal_zero_flag
);
	function automatic logic is_bcd(input logic [15:0] w);
		return w[3:0] < 4'hA && w[7:4] < 4'hA && w[11:8] < 4'hA
			&& w[15:12] < 4'hA;
	endfunction
	wire logic take = start && !busy && exec_cond;
	wire logic fin = done && exec_cond && !error_flag;
	wire logic hms_ok = is_bcd(src0) && is_bcd(src1) && src_area_ok
		&& res_area_ok && src0[7:0] <= 8'h59 && src0[15:8] <= 8'h59;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);
	sequence s_err_done;
		done && error_flag;
	endsequence
	sequence s_kept;
		$stable(res0) && $stable(res1) && $stable(error_flag)
			&& $stable(carry_sign_flag) && $stable(equal_zero_flag);
	endsequence
	AST_NOEXEC_KEEP: assert property (
		start && !busy && !exec_cond |=> done ##0 s_kept ##1 s_kept)
		else $error("outputs moved with condition off");
	AST_DONE_PULSE: assert property (done |=> !done)
		else $error("done too long");
	AST_HMS_TIME: assert property (
		take && op_sel == LSTC_OP_HMS && hms_ok |-> ##29 done)
		else $error("time conversion latency");
	AST_ERR_AREA: assert property (
		take && op_sel == LSTC_OP_B2BCD && !prm_area_ok |=> s_err_done)
		else $error("area fault not flagged");
	AST_ERR_DIGIT: assert property (
		take && op_sel == LSTC_OP_BCD2B && !is_bcd(src0) |=> s_err_done)
		else $error("bad digit not flagged");
	AST_ERR_FIELD: assert property (
		take && op_sel == LSTC_OP_HMS
			&& (src0[7:0] > 8'h59 || src0[15:8] > 8'h59) |=> s_err_done)
		else $error("bad field not flagged");
	AST_SIGN_KEPT: assert property (
		fin && op_sel == LSTC_OP_BCD2B |-> carry_sign_flag == carry_in)
		else $error("sign changed");
	AST_EQ_SCALE: assert property (
		fin && op_sel != LSTC_OP_HMS |-> equal_zero_flag == (res0 == 0))
		else $error("zero flag wrong");
	AST_EQ_HMS: assert property (
		fin && op_sel == LSTC_OP_HMS
			|-> equal_zero_flag == (res0 == 0 && res1 == 0))
		else $error("zero flag wrong on time");
	AST_BCD_MAG: assert property (
		fin && op_sel == LSTC_OP_B2BCD
			|-> is_bcd(res0) && !(res0 == 0 && carry_sign_flag))
		else $error("bad magnitude");
	AST_HMS_MAX: assert property (
		fin && op_sel == LSTC_OP_HMS
			|-> is_bcd(res0) && is_bcd(res1) && res1 <= 16'h3599)
		else $error("seconds out of range");
endmodule

/* bench/linear_scaling_time_convert_tb_top.sv */
`timescale 1ns/100ps
module linear_scaling_time_convert_tb_top
	import lstc_pkg::*;
;
	typedef struct {
		logic [1:0] op;
		logic [15:0] s0;
		logic [15:0] s1;
		logic [2:0] ps;
		logic [15:0] r0;
		logic [15:0] r1;
		logic [2:0] st;
	} lstc_row_t;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic [5:0] address = 6'h00;
	logic read = 1'b0;
	logic write = 1'b0;
	logic [31:0] writedata = 32'h0000_0000;
	logic [31:0] readdata;
	logic waitrequest;
	logic irq;
	logic ce = 1'b1;
	logic [31:0] q;
	int error_cnt = 0;
	int check_count = 0;
	logic [0:4][15:0] psets [6] = '{
		{16'h0000, 16'h0001, 16'h0001, 16'h07FF, 16'hF800},
		{16'h0000, 16'h0005, 16'h0003, 16'h07FF, 16'hF800},
		{16'h0010, 16'h0001, 16'h0001, 16'h07FF, 16'hF800},
		{16'h0000, 16'h0002, 16'h0001, 16'h07FF, 16'hF800},
		{16'h0005, 16'h0003, 16'h0005, 16'h07FF, 16'hF800},
		{16'h0005, 16'h0003, 16'hFFFA, 16'h07FF, 16'hF800}
	};
	// st holds expected {equal, carry, error}
	lstc_row_t rows [13] = '{
		'{2'h0, 16'h0005, 16'h0000, 3'h0, 16'h0005, 16'h0000, 3'h0},
		'{2'h0, 16'hFFE2, 16'h0000, 3'h1, 16'h0018, 16'h0000, 3'h2},
		'{2'h0, 16'h7FFF, 16'h0000, 3'h0, 16'h9999, 16'h0000, 3'h0},
		'{2'h0, 16'h8000, 16'h0000, 3'h0, 16'h9999, 16'h0000, 3'h2},
		'{2'h0, 16'h0010, 16'h0000, 3'h2, 16'h0000, 16'h0000, 3'h4},
		'{2'h0, 16'h0003, 16'h0000, 3'h3, 16'h0002, 16'h0000, 3'h0},
		'{2'h1, 16'h0100, 16'h0000, 3'h4, 16'h00AC, 16'h0000, 3'h0},
		'{2'h1, 16'h1035, 16'h0000, 3'h5, 16'h07FF, 16'h0000, 3'h2},
		'{2'h1, 16'h1035, 16'h0000, 3'h5, 16'hF800, 16'h0000, 3'h0},
		'{2'h1, 16'h0000, 16'h0000, 3'h0, 16'h0000, 16'h0000, 3'h4},
		'{2'h2, 16'h5959, 16'h9999, 3'h0, 16'h9999, 16'h3599, 3'h0},
		'{2'h2, 16'h0000, 16'h0000, 3'h0, 16'h0000, 16'h0000, 3'h4},
		'{2'h2, 16'h0130, 16'h0002, 3'h0, 16'h7290, 16'h0000, 3'h0}
	};
	logic [1:0] err_op [4] = '{2'h1, 2'h2, 2'h0, 2'h3};
	logic [15:0] err_s0 [4] = '{16'h00A0, 16'h0060, 16'h0001, 16'h0001};
	logic [15:0] dests [3] = '{16'h1800, 16'h19FF, 16'h1A00};
	always #2 clk = ~clk;
	lstc_if lstc_if_i ();
	lstc_unit lstc_unit_i (
		.clk(clk),
		.reset_n(reset_n),
		.ce(ce),
		.link(lstc_if_i)
	);
	lstc_seq lstc_seq_i (
		.clk(clk),
		.reset_n(reset_n),
		.ce(ce),
		.address(address),
		.read(read),
		.write(write),
		.writedata(writedata),
		.readdata(readdata),
		.waitrequest(waitrequest),
		.irq(irq),
		.link(lstc_if_i)
	);
	lstc_assertions lstc_assertions_i (
		.clk(clk),
		.reset_n(reset_n),
		.start(lstc_if_i.start),
		.op_sel(lstc_if_i.op_sel),
		.exec_cond(lstc_if_i.exec_cond),
		.carry_in(lstc_if_i.carry_in),
		.src0(lstc_if_i.src0),
		.src1(lstc_if_i.src1),
		.src_area_ok(lstc_if_i.src_area_ok),
		.prm_area_ok(lstc_if_i.prm_area_ok),
		.res_area_ok(lstc_if_i.res_area_ok),
		.done(lstc_if_i.done),
		.busy(lstc_if_i.busy),
		.res0(lstc_if_i.res0),
		.res1(lstc_if_i.res1),
		.error_flag(lstc_if_i.error_flag),
		.carry_sign_flag(lstc_if_i.carry_sign_flag),
		.equal_zero_flag(lstc_if_i.equal_zero_flag)
	);
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic fail(input string what);
		error_cnt++;
		$display("BAD %0t %s", $time, what);
		tally_and_finish();
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
		input string what);
		check_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("BAD %0t %s saw %h want %h", $time, what, seen, exp);
		end
	endtask
	task automatic bus(input logic wr, input logic [5:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		address <= a;
		write <= wr;
		read <= !wr;
		writedata <= d;
		do begin
			@(posedge clk);
			n++;
		end while (waitrequest !== 1'b0 && n < 100);
		if (waitrequest !== 1'b0) fail("bus hang");
		q = readdata;
		read <= 1'b0;
		write <= 1'b0;
	endtask
	task automatic rd_chk(input logic [5:0] a, input logic [31:0] e,
		input string what);
		bus(1'b0, a, 32'h0000_0000);
		chk(q, e, what);
	endtask
	task automatic load(input logic [15:0] s0, input logic [15:0] s1,
		input logic [0:4][15:0] p);
		bus(1'b1, LSTC_REG_SRC0, {16'h0000, s0});
		bus(1'b1, LSTC_REG_SRC1, {16'h0000, s1});
		for (int i = 0; i < 5; i++) begin
			bus(1'b1, LSTC_REG_PRM0 + 6'(4 * i), {16'h0000, p[i]});
		end
	endtask
	task automatic wait_done();
		int n;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (lstc_if_i.done !== 1'b1 && n < 200);
		if (lstc_if_i.done !== 1'b1) fail("no done");
	endtask
	task automatic go(input logic [1:0] op, input logic ex,
		input logic cy, input logic wt);
		bus(1'b1, LSTC_REG_CTRL, cy ? 32'h0000_0010 : 32'h0000_0020);
		bus(1'b1, LSTC_REG_CTRL, {28'h000_0000, 1'b1, ex, op});
		if (wt) begin
			wait_done();
		end
	endtask
	initial begin
		repeat (20) @(posedge clk);
		reset_n <= 1'b1;
		chk(32'(irq), 32'h0000_0000, "irq reset");
		rd_chk(LSTC_REG_STAT, 32'h0000_0000, "stat reset");
		rd_chk(LSTC_REG_AREA, 32'h0000_0007, "area reset");
		rd_chk(LSTC_REG_RES0, 32'h0000_0000, "res reset");
		bus(1'b1, 6'h3C, 32'h0000_1234);
		rd_chk(6'h3C, 32'h0000_0000, "unmapped");
		$display("test reset done");
		foreach (rows[i]) begin
			load(rows[i].s0, rows[i].s1, psets[rows[i].ps]);
			go(rows[i].op, 1'b1, rows[i].st[1], 1'b1);
			rd_chk(LSTC_REG_RES0, {16'h0000, rows[i].r0}, "res0");
			rd_chk(LSTC_REG_RES1, {16'h0000, rows[i].r1}, "res1");
			bus(1'b0, LSTC_REG_STAT, 32'h0000_0000);
			chk({29'h0, q[3:1]}, {29'h0, rows[i].st}, "flags");
			$display("test row %0d done", i);
		end
		chk(32'(irq), 32'h0000_0000, "irq masked");
		rd_chk(LSTC_REG_IRQ_STAT, 32'h0000_0001, "irq status");
		bus(1'b1, LSTC_REG_IRQ_MASK, 32'h0000_0007);
		load(16'h0000, 16'h0000, psets[0]);
		go(LSTC_OP_HMS, 1'b0, 1'b0, 1'b1);
		rd_chk(LSTC_REG_RES0, 32'h0000_7290, "noexec res");
		rd_chk(LSTC_REG_STAT, 32'h0000_0000, "noexec flags");
		chk(32'(irq), 32'h0000_0001, "irq raised");
		rd_chk(LSTC_REG_IRQ_STAT, 32'h0000_0001, "irq done");
		@(posedge clk);
		chk(32'(irq), 32'h0000_0000, "irq cleared");
		$display("test noexec done");
		for (int i = 0; i < 4; i++) begin
			bus(1'b1, LSTC_REG_AREA, i == 2 ? 32'h0000_0005 : 32'h0000_0007);
			load(16'h0001, 16'h0000, psets[0]);
			go(LSTC_OP_HMS, 1'b1, 1'b0, 1'b1);
			load(err_s0[i], 16'h0000, psets[0]);
			go(err_op[i], 1'b1, 1'b0, 1'b1);
			bus(1'b0, LSTC_REG_STAT, 32'h0000_0000);
			chk(32'(q[1]), 32'h0000_0001, "error flag");
			rd_chk(LSTC_REG_RES0, 32'h0000_0001, "error res");
			chk(32'(irq), 32'h0000_0001, "irq error");
			rd_chk(LSTC_REG_IRQ_STAT, 32'h0000_0003, "irq events");
			$display("test error %0d done", i);
		end
		bus(1'b1, LSTC_REG_AREA, 32'h0000_0007);
		for (int i = 0; i < 3; i++) begin
			bus(1'b1, LSTC_REG_DEST, {16'h0000, dests[i]});
			load(16'h0002, 16'h0000, psets[0]);
			go(LSTC_OP_HMS, 1'b1, 1'b0, i == 2);
			rd_chk(LSTC_REG_IRQ_STAT, i == 2 ? 32'h0000_0001 : 32'h0000_0004,
				"refusal");
			rd_chk(LSTC_REG_RES0, i == 2 ? 32'h0000_0002 : 32'h0000_0001,
				"dest res");
			$display("test dest %0d done", i);
		end
		bus(1'b1, LSTC_REG_CTRL, 32'h0000_000C);
		repeat (10) @(posedge clk);
		reset_n <= 1'b0;
		repeat (3) @(posedge clk);
		reset_n <= 1'b1;
		chk(32'(lstc_if_i.busy), 32'h0000_0000, "busy mid reset");
		rd_chk(LSTC_REG_STAT, 32'h0000_0000, "stat mid reset");
		rd_chk(LSTC_REG_RES0, 32'h0000_0000, "res mid reset");
		rd_chk(LSTC_REG_AREA, 32'h0000_0007, "area mid reset");
		$display("test mid reset done");
		load(16'h0100, 16'h0000, psets[4]);
		go(LSTC_OP_BCD2B, 1'b1, 1'b0, 1'b0);
		repeat (5) @(posedge clk);
		ce <= 1'b0;
		repeat (40) @(posedge clk);
		chk(32'(lstc_if_i.busy), 32'h0000_0001, "busy frozen");
		chk(32'(lstc_if_i.done), 32'h0000_0000, "done frozen");
		ce <= 1'b1;
		wait_done();
		rd_chk(LSTC_REG_RES0, 32'h0000_00AC, "res after freeze");
		$display("test clock enable done");
		tally_and_finish();
	end
endmodule
